/* dv/ars_dma_model.sv */
// DMA receive counter model facing the result block
`timescale 1ns/1ps
`default_nettype none
module ars_dma_model
  import ars_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Software loads and transfer steps
  input  wire logic       ld_cur,
  input  wire logic       ld_next,
  input  wire ars_count_t ld_val,
  input  wire logic       step,
  // Counter side of the block
  output var  ars_count_t cnt,
  output var  ars_count_t cnt_next,
  output logic            cnt_wr,
  output logic            cnt_next_wr
);
  ////////////////////////////////////////////////////////////////////////
  // Count down per transfer; no reload, so zero stays until software acts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt         <= 16'h0000;
      cnt_next    <= 16'h0000;
      cnt_wr      <= 1'b0;
      cnt_next_wr <= 1'b0;
    end else begin
      cnt_wr      <= ld_cur;
      cnt_next_wr <= ld_next;
      if (ld_cur) begin
        cnt <= ld_val;
      end else if (step && cnt != 16'h0000) begin
        cnt <= cnt - 16'h0001;
      end
      if (ld_next) begin
        cnt_next <= ld_val;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/ars_regs_bench.sv */
// Self-checking bench of the result, status and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "ars_map.svh"
module ars_regs_bench
  import ars_pkg::*;
;
  logic        clk, rst, bus_wr, bus_rd, conv_done, irq, rc_wr, nrc_wr;
  logic        ld_cur, ld_next, step, rd_q, probe;
  logic [7:0]  bus_addr, channel_enable;
  logic [31:0] bus_wdata, bus_rdata, m, r, rx;
  logic [2:0]  conv_channel;
  ars_sample_t conv_data, d1, d2, d3;
  ars_sample_t vals [8];
  ars_count_t  rc, nrc, ld_val;
  logic [31:0] word_q [$];
  logic        irq_q [$];
  int          fail_count, total_checks, seed;

  ars_regs uut (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .conv_done(conv_done),
    .conv_channel(conv_channel), .conv_data(conv_data),
    .channel_enable(channel_enable), .dma_receive_count(rc),
    .dma_next_receive_count(nrc), .dma_receive_count_wr(rc_wr),
    .dma_next_receive_count_wr(nrc_wr), .irq(irq));
  ars_dma_model dma (.clk(clk), .rst(rst), .ld_cur(ld_cur),
    .ld_next(ld_next), .ld_val(ld_val), .step(step), .cnt(rc),
    .cnt_next(nrc), .cnt_wr(rc_wr), .cnt_next_wr(nrc_wr));

  ////////////////////////////////////////////////////////////////////////
  // Comparisons and verdict
  task automatic cmp_word(string what, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_bit(string what, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic summarize;
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Drivers: one-cycle strobes, expectations queued as they are issued
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    word_q.push_back(e);
    @(posedge clk);
    bus_rd <= 1'b0;
  endtask
  // Waits so the level output has settled before it is probed
  task automatic chk_irq(logic e);
    repeat (3) @(posedge clk);
    irq_q.push_back(e);
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
  endtask
  task automatic conv(logic [2:0] ch, ars_sample_t d);
    @(posedge clk);
    conv_done    <= 1'b1;
    conv_channel <= ch;
    conv_data    <= d;
    @(posedge clk);
    conv_done <= 1'b0;
  endtask
  // Extra cycles cover the counter model and the full flag's lag
  task automatic dma_op(logic c, logic n, ars_count_t v, logic s);
    @(posedge clk);
    ld_cur  <= c;
    ld_next <= n;
    ld_val  <= v;
    step    <= s;
    @(posedge clk);
    {ld_cur, ld_next, step} <= 3'b000;
    repeat (2) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Monitor: read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_q) cmp_word("bus_rdata", word_q.pop_front(), bus_rdata);
    if (probe) cmp_bit("irq", irq_q.pop_front(), irq);
    rd_q <= bus_rd;
  end

  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    {bus_wr, bus_rd, conv_done, ld_cur, ld_next, step} = 6'h00;
    {rd_q, probe, bus_addr, bus_wdata, conv_channel} = '0;
    {channel_enable, conv_data, ld_val} = '0;
    fail_count = 0;
    total_checks = 0;
    seed = 71983;
    rx = 32'h000c0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`ARS_OFF_STATUS, rx);
    rd(`ARS_OFF_IRQ_MASK, 32'h0);
    wr(`ARS_OFF_LAST, 32'hffffffff);
    rd(`ARS_OFF_LAST, 32'h0);
    rd(8'h50, 32'h0);
    m = $random(seed) & 32'h000fffff;
    wr(`ARS_OFF_IRQ_SET, m);
    wr(`ARS_OFF_IRQ_SET, 32'h0);
    rd(`ARS_OFF_IRQ_MASK, m);
    r = $random(seed);
    wr(`ARS_OFF_IRQ_CLR, r);
    wr(`ARS_OFF_IRQ_CLR, 32'h0);
    rd(`ARS_OFF_IRQ_MASK, m & ~r);
    wr(`ARS_OFF_IRQ_SET, 32'hffffffff);
    rd(`ARS_OFF_IRQ_MASK, 32'h000fffff);
    chk_irq(1'b1);
    wr(`ARS_OFF_IRQ_CLR, 32'hffffffff);
    chk_irq(1'b0);
    // Every channel in turn; ready stays set so later ones overrun
    channel_enable <= 8'hff;
    wr(`ARS_OFF_IRQ_SET, 32'h00010000);
    for (int i = 0; i < 8; i++) begin
      vals[i] = ars_sample_t'($random(seed));
      conv(3'(i), vals[i]);
      rd(8'(`ARS_OFF_CHAN0 + 4 * i), {22'h0, vals[i]});
    end
    chk_irq(1'b1);
    rd(`ARS_OFF_STATUS, rx | 32'h00030000);
    rd(`ARS_OFF_STATUS, rx | 32'h00010000);
    rd(`ARS_OFF_LAST, {22'h0, vals[7]});
    chk_irq(1'b0);
    rd(`ARS_OFF_STATUS, rx);
    // Overrun on one channel, then disable it and convert elsewhere
    d1 = ars_sample_t'($random(seed));
    d2 = ars_sample_t'($random(seed));
    d3 = ars_sample_t'($random(seed));
    channel_enable <= 8'h08;
    conv(3'd3, d1);
    rd(`ARS_OFF_STATUS, rx | 32'h00010008);
    conv(3'd3, d2);
    rd(`ARS_OFF_STATUS, rx | 32'h00030808);
    rd(`ARS_OFF_STATUS, rx | 32'h00010008);
    rd(`ARS_OFF_LAST, {22'h0, d2});
    channel_enable <= 8'h00;
    rd(`ARS_OFF_STATUS, rx);
    rd(8'h3c, {22'h0, d2});
    conv(3'd5, d3);
    rd(8'h44, {22'h0, vals[5]});
    rd(`ARS_OFF_STATUS, rx | 32'h00010000);
    rd(`ARS_OFF_LAST, {22'h0, d3});
    // Receive counter runs down to zero, then next counter is loaded
    wr(`ARS_OFF_IRQ_CLR, 32'hffffffff);
    wr(`ARS_OFF_IRQ_SET, 32'h00040000);
    dma_op(1'b1, 1'b0, 16'h0002, 1'b0);
    rd(`ARS_OFF_STATUS, 32'h0);
    chk_irq(1'b0);
    dma_op(1'b0, 1'b0, 16'h0000, 1'b1);
    rd(`ARS_OFF_STATUS, 32'h0);
    dma_op(1'b0, 1'b0, 16'h0000, 1'b1);
    rd(`ARS_OFF_STATUS, 32'h000c0000);
    chk_irq(1'b1);
    dma_op(1'b0, 1'b1, 16'h0005, 1'b0);
    rd(`ARS_OFF_STATUS, 32'h0);
    chk_irq(1'b0);
    // Mid-run reset with every source enabled must clear the mask
    wr(`ARS_OFF_IRQ_SET, 32'hffffffff);
    rd(`ARS_OFF_IRQ_MASK, 32'h000fffff);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`ARS_OFF_IRQ_MASK, 32'h0);
    rd(`ARS_OFF_STATUS, rx);
    chk_irq(1'b0);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule
`default_nettype wire

/* verilog/ars_map.svh */
// Register offsets, field positions and reset values of the result block
`ifndef ARS_MAP_SVH
`define ARS_MAP_SVH

// Byte offsets on the register port
`define ARS_OFF_STATUS   8'h1c
`define ARS_OFF_LAST     8'h20
`define ARS_OFF_IRQ_SET  8'h24
`define ARS_OFF_IRQ_CLR  8'h28
`define ARS_OFF_IRQ_MASK 8'h2c
`define ARS_OFF_CHAN0    8'h30
`define ARS_OFF_CHAN7    8'h4c

// Field positions shared by status, enable, disable and mask
`define ARS_BIT_DONE     0
`define ARS_BIT_OVR      8
`define ARS_BIT_READY    16
`define ARS_BIT_GOVR     17
`define ARS_BIT_RXDONE   18
`define ARS_BIT_RXFULL   19
`define ARS_FLAG_MSB     19

// Reset values
`define ARS_RST_DATA     10'h000
`define ARS_RST_FLAGS8   8'h00
`define ARS_RST_MASK     20'h00000
`define ARS_RST_RXDONE   1'b1
`define ARS_RST_RXFULL   1'b1
`define ARS_RST_WORD     32'h0000_0000

`endif

/* verilog/ars_pkg.sv */
// Types of the result, status and interrupt block
`default_nettype none
package ars_pkg;
  `include "ars_map.svh"

  typedef logic [9:0]  ars_sample_t;
  typedef logic [15:0] ars_count_t;

  // Whole state of the block, registered as one word
  typedef struct packed {
    ars_sample_t           last_data;
    logic [7:0][9:0]       chan_data;
    logic [7:0]            done;
    logic [7:0]            ovr;
    logic                  ready;
    logic                  govr;
    logic                  rxdone;
    logic                  rxfull;
    logic [`ARS_FLAG_MSB:0] mask;
    logic                  cnt_zero;
    logic [31:0]           rdata;
    logic                  irq;
  } ars_state_t;
endpackage
`default_nettype wire

/* verilog/ars_regs.sv */
// Result, status and interrupt registers of an eight-channel converter
//
// Operation
// - The data-ready flag sets when a result lands in the last-result register and clears when that register is read.
// - The general overrun flag sets on any general overrun and stays set until the status register is read or a one is written to its status bit.
// - The end-of-receive flag rises when the receive count reaches zero and clears on a write to either receive count.
// - The buffers-full flag is one only while both receive counts are zero.
// - The last-result field takes the value of every conversion and holds it until the next one.
// - Writing a one to the enable register sets that mask bit; a zero leaves it alone.
// - Writing a one to the disable register clears that mask bit; a zero leaves it alone.
// - The mask register reads one for each enabled source and zero for each disabled one.
// - Enable, disable and mask share the status layout: done 7..0, overrun 15..8, then ready, general overrun, end-of-receive and full at 16..19.
// - A channel result register changes only for conversions of an enabled channel.
// - A channel result register captures the ten-bit value when its conversion ends and keeps it.
// - A conversion-done flag reads one only while its channel is enabled and its conversion has finished.
// - A channel overrun flag records an overrun since its last clear and clears on a status read or on a one written to its status bit.
`timescale 1ns/1ps
`default_nettype none
`include "ars_map.svh"
module ars_regs
  import ars_pkg::*;
(
  // Clock and reset
  input  wire  logic        clk,
  input  wire  logic        rst,
  // Register port
  input  wire  logic [7:0]  bus_addr,
  input  wire  logic [31:0] bus_wdata,
  input  wire  logic        bus_wr,
  input  wire  logic        bus_rd,
  output logic       [31:0] bus_rdata,
  // Conversion results from the sequencer
  input  wire  logic        conv_done,
  input  wire  logic [2:0]  conv_channel,
  input  wire  ars_sample_t conv_data,
  input  wire  logic [7:0]  channel_enable,
  // Receive counters of the DMA channel
  input  wire  ars_count_t  dma_receive_count,
  input  wire  ars_count_t  dma_next_receive_count,
  input  wire  logic        dma_receive_count_wr,
  input  wire  logic        dma_next_receive_count_wr,
  // Interrupt
  output logic              irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State and decode

  ars_state_t st;
  ars_state_t next_st;

  logic       rd_status;
  logic       wr_status;
  logic       rd_last;
  logic       in_chan;
  logic       rd_chan;
  logic [2:0] addr_chan;
  logic       conv_on;
  logic       cnt_zero;
  logic       rx_written;
  logic [7:0] clr_done;
  logic [7:0] clr_ovr;

  // Status word as software sees it; done bits masked by channel enable
  function automatic logic [31:0] status_word(input ars_state_t s,
                                              input logic [7:0] en);
    logic [31:0] w;
    w = `ARS_RST_WORD;
    w[`ARS_BIT_DONE +: 8] = s.done & en;
    w[`ARS_BIT_OVR +: 8]  = s.ovr;
    w[`ARS_BIT_READY]     = s.ready;
    w[`ARS_BIT_GOVR]      = s.govr;
    w[`ARS_BIT_RXDONE]    = s.rxdone;
    w[`ARS_BIT_RXFULL]    = s.rxfull;
    return w;
  endfunction

  // Address decode; channel window is eight consecutive words
  assign rd_status = bus_rd && (bus_addr == `ARS_OFF_STATUS);
  assign wr_status = bus_wr && (bus_addr == `ARS_OFF_STATUS);
  assign rd_last   = bus_rd && (bus_addr == `ARS_OFF_LAST);
  assign in_chan   = (bus_addr >= `ARS_OFF_CHAN0) &&
                     (bus_addr <= `ARS_OFF_CHAN7);
  assign rd_chan   = bus_rd && in_chan;
  assign addr_chan = 3'(bus_addr[7:2] - 6'(`ARS_OFF_CHAN0 >> 2));

  // Conversion of an enabled channel, receive counter events
  assign conv_on    = conv_done && channel_enable[conv_channel];
  assign cnt_zero   = (dma_receive_count == 16'h0000);
  assign rx_written = dma_receive_count_wr || dma_next_receive_count_wr;

  // Clears: status read wipes overruns, write-one also accepted
  assign clr_ovr  = rd_status ? 8'hff :
                    (wr_status ? bus_wdata[`ARS_BIT_OVR +: 8] : 8'h00);
  assign clr_done = rd_chan ? (8'h01 << addr_chan) : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;

    // Results: last value always, channel copy only when enabled
    if (conv_done) begin
      next_st.last_data = conv_data;
    end
    if (conv_on) begin
      next_st.chan_data[conv_channel] = conv_data;
    end

    // Clears first, so an event in the same cycle wins
    next_st.done = st.done & ~clr_done & channel_enable;
    next_st.ovr  = st.ovr & ~clr_ovr;
    if (rd_status || (wr_status && bus_wdata[`ARS_BIT_GOVR])) begin
      next_st.govr = 1'b0;
    end
    if (rd_last || (wr_status && bus_wdata[`ARS_BIT_READY])) begin
      next_st.ready = 1'b0;
    end
    if (rx_written || (wr_status && bus_wdata[`ARS_BIT_RXDONE])) begin
      next_st.rxdone = 1'b0;
    end

    // Channel flags; finishing over an unread result is an overrun
    if (conv_on) begin
      next_st.ovr[conv_channel]  = next_st.ovr[conv_channel] |
                                   st.done[conv_channel];
      next_st.done[conv_channel] = 1'b1;
    end
    // General overrun when the last result was never read
    if (conv_done) begin
      next_st.govr  = next_st.govr | st.ready;
      next_st.ready = 1'b1;
    end

    // Receive counter reaching zero is an edge, not a level
    if (cnt_zero && !st.cnt_zero) begin
      next_st.rxdone = 1'b1;
    end
    next_st.cnt_zero = cnt_zero;
    next_st.rxfull   = cnt_zero &&
                       (dma_next_receive_count == 16'h0000);

    // Mask set and clear; strobes never coincide
    if (bus_wr && (bus_addr == `ARS_OFF_IRQ_SET)) begin
      next_st.mask = st.mask | bus_wdata[`ARS_FLAG_MSB:0];
    end
    if (bus_wr && (bus_addr == `ARS_OFF_IRQ_CLR)) begin
      next_st.mask = st.mask & ~bus_wdata[`ARS_FLAG_MSB:0];
    end

    // Read data stands one cycle; unmapped and idle give zero
    next_st.rdata = `ARS_RST_WORD;
    if (bus_rd) begin
      if (bus_addr == `ARS_OFF_STATUS) begin
        next_st.rdata = status_word(st, channel_enable);
      end else if (bus_addr == `ARS_OFF_LAST) begin
        next_st.rdata[9:0] = st.last_data;
      end else if (bus_addr == `ARS_OFF_IRQ_MASK) begin
        next_st.rdata[`ARS_FLAG_MSB:0] = st.mask;
      end else if (in_chan) begin
        next_st.rdata[9:0] = st.chan_data[addr_chan];
      end
    end

    // Level interrupt from the coming state, so it lands with the flags
    next_st.irq = |(status_word(next_st, channel_enable)
                    & {12'h000, next_st.mask});
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st.last_data <= `ARS_RST_DATA;
      st.chan_data <= '0;
      st.done      <= `ARS_RST_FLAGS8;
      st.ovr       <= `ARS_RST_FLAGS8;
      st.ready     <= 1'b0;
      st.govr      <= 1'b0;
      st.rxdone    <= `ARS_RST_RXDONE;
      st.rxfull    <= `ARS_RST_RXFULL;
      st.mask      <= `ARS_RST_MASK;
      st.cnt_zero  <= 1'b1;
      st.rdata     <= `ARS_RST_WORD;
      st.irq       <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign bus_rdata = st.rdata;
  assign irq       = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_last_read;
    rd_last && !conv_done;
  endsequence

  sequence s_status_read;
    rd_status && !conv_done;
  endsequence

  property p_ready_set;
    conv_done |=> st.ready ##0 (st.last_data == $past(conv_data));
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("data ready or last value missing after conversion");

  property p_ready_clear;
    s_last_read |=> !st.ready;
  endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("data ready not cleared by last-result read");

  property p_govr_set_clear;
    (conv_done && st.ready |=> st.govr) and
    (s_status_read |=> !st.govr);
  endproperty
  a_govr_set_clear: assert property (p_govr_set_clear)
    else $error("general overrun flag wrong");

  property p_rxdone;
    (rx_written && !(cnt_zero && !st.cnt_zero) |=> !st.rxdone) and
    (cnt_zero && !st.cnt_zero |=> st.rxdone);
  endproperty
  a_rxdone: assert property (p_rxdone)
    else $error("end-of-receive flag wrong");

  property p_rxfull;
    ##1 st.rxfull == $past(cnt_zero && dma_next_receive_count == 16'h0000);
  endproperty
  a_rxfull: assert property (p_rxfull)
    else $error("buffers-full flag does not follow counters");

  property p_last_hold;
    !conv_done [*2] |-> $stable(st.last_data);
  endproperty
  a_last_hold: assert property (p_last_hold)
    else $error("last result changed without conversion");

  property p_mask_set;
    bus_wr && bus_addr == `ARS_OFF_IRQ_SET |=>
      ((st.mask & $past(bus_wdata[19:0])) == $past(bus_wdata[19:0])) &&
      ((st.mask & ~$past(bus_wdata[19:0])) ==
       ($past(st.mask) & ~$past(bus_wdata[19:0])));
  endproperty
  a_mask_set: assert property (p_mask_set)
    else $error("enable write did not set mask correctly");

  property p_mask_clr;
    bus_wr && bus_addr == `ARS_OFF_IRQ_CLR |=>
      st.mask == ($past(st.mask) & ~$past(bus_wdata[19:0]));
  endproperty
  a_mask_clr: assert property (p_mask_clr)
    else $error("disable write did not clear mask correctly");

  property p_mask_read;
    bus_rd && bus_addr == `ARS_OFF_IRQ_MASK |=>
      bus_rdata == {12'h000, $past(st.mask)};
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read value wrong");

  property p_status_layout;
    rd_status |=> bus_rdata[`ARS_BIT_READY] == $past(st.ready) &&
      bus_rdata[`ARS_BIT_RXFULL] == $past(st.rxfull) &&
      bus_rdata[15:8] == $past(st.ovr) && bus_rdata[31:20] == 12'h000;
  endproperty
  a_status_layout: assert property (p_status_layout)
    else $error("status word layout wrong");

  property p_chan_off;
    conv_done && !channel_enable[conv_channel] |=> $stable(st.chan_data);
  endproperty
  a_chan_off: assert property (p_chan_off)
    else $error("disabled channel result changed");

  property p_chan_load;
    conv_on |=> st.chan_data[$past(conv_channel)] == $past(conv_data) &&
                st.done[$past(conv_channel)];
  endproperty
  a_chan_load: assert property (p_chan_load)
    else $error("channel result not captured");

  property p_done_gated;
    rd_status |=> (bus_rdata[7:0] & ~$past(channel_enable)) == 8'h00;
  endproperty
  a_done_gated: assert property (p_done_gated)
    else $error("done flag shown for disabled channel");

  property p_ovr;
    (conv_on && st.done[conv_channel] |=> st.ovr[$past(conv_channel)]) and
    (s_status_read |=> st.ovr == 8'h00);
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("channel overrun flag wrong");

  property p_irq;
    irq == |(status_word(st, $past(channel_enable)) & {12'h000, st.mask});
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output disagrees with flags and mask");

  property p_mask_reset;
    $fell(rst) |-> st.mask == `ARS_RST_MASK;
  endproperty
  a_mask_reset: assert property (@(posedge clk) p_mask_reset)
    else $error("mask not clear after reset");

  property p_last_read;
    rd_last |=> bus_rdata == {22'h000000, $past(st.last_data)};
  endproperty
  a_last_read: assert property (p_last_read)
    else $error("last result read value wrong");

  property p_chan_read;
    rd_chan |=> bus_rdata == {22'h000000, $past(st.chan_data[addr_chan])};
  endproperty
  a_chan_read: assert property (p_chan_read)
    else $error("channel result read value wrong");

  property p_done_off;
    ##1 (st.done & ~$past(channel_enable)) == 8'h00;
  endproperty
  a_done_off: assert property (p_done_off)
    else $error("done flag kept for disabled channel");

  property p_done_read;
    rd_chan && !conv_on |=> !st.done[$past(addr_chan)];
  endproperty
  a_done_read: assert property (p_done_read)
    else $error("done flag not cleared by channel read");

endmodule
`default_nettype wire
